// ==== rtl/ebi_mux_pkg.sv ====
// Constants and carrier types for the external bus pin-sharing logic.
package ebi_mux_pkg;
	localparam int CTL_COUNT = 3;
	localparam logic [1:0] OWN_STATIC = 2'h0;
	localparam logic [1:0] OWN_DYNAMIC = 2'h1;
	localparam logic [1:0] OWN_BURST = 2'h2;
	localparam logic [3:0] CARD_REGION = 4'h5;
	localparam int IO_MODE_BIT = 23;
	localparam int CS_COUNT = 7;
	localparam int CS_CARD = 4;
	localparam int CS_BE_LOW = 5;
	localparam int CS_BE_HIGH = 6;
	localparam logic [3:0] FLOAT_RESET = 4'h0;
	localparam logic [25:0] ADDR_RESET = 26'h0000000;
	localparam logic [31:0] DATA_RESET = 32'h00000000;
	localparam logic [2:0] GRANT_RESET = 3'h0;
	localparam logic [6:0] CS_IDLE = 7'h7f;
	localparam logic [15:0] PULLUP_RESET = 16'hffff;
	localparam logic [3:0] SDRAM_CMD_IDLE = 4'hf;
	localparam logic [2:0] WAIT_SYNC_RESET = 3'h0;

	// One controller's view of the shared pins; strobes are active low.
	typedef struct packed {
		logic want;
		logic [25:0] addr;
		logic [31:0] wdata;
		logic drive;
		logic read_not_write;
		logic rd_b;
		logic wr0_b;
		logic wr1_b;
		logic wr3_b;
		logic [6:0] cs_b;
		logic [1:0] lanes;
		logic [3:0] float_cycles;
	} ctl_s;

	// Shared strobe pins as they leave the block.
	typedef struct packed {
		logic oe_b;
		logic we0_b;
		logic wr1_b;
		logic wr3_b;
	} strobe_s;
endpackage

// ==== rtl/ext_bus_pin_mux_card_logic.sv ====
// Pin multiplexer that shares the external bus pins and decodes card modes.
`timescale 1ns/1ns
module ext_bus_pin_mux_card_logic
(
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input ebi_mux_pkg::ctl_s static_memory_ctrl_i,
	input ebi_mux_pkg::ctl_s dynamic_memory_ctrl_i,
	input ebi_mux_pkg::ctl_s burst_nor_ctrl_i,
	input wire logic [31:0] static_xfer_addr_i,
	input wire logic cs4_wide_i,
	input wire logic burst_in_page_i,
	input wire logic [3:0] sdram_cmd_i,
	input wire logic card_slot_assign_i,
	input wire logic data_bus_pullup_disable_i,
	input wire logic external_wait_input_i,
	output logic [2:0] grant_o,
	output logic [25:0] addr_o,
	output logic [31:0] data_o,
	output logic data_oe_o,
	output logic [6:0] cs_b_o,
	output ebi_mux_pkg::strobe_s strobe_o,
	output logic [3:0] sdram_cmd_o,
	output logic [15:0] pullup_en_o,
	output logic wait_sync_o
);
	typedef enum logic [1:0] {ST_IDLE, ST_OWN, ST_FLOAT} arb_e;

	arb_e state_q;
	arb_e state_d;
	logic [1:0] owner_q;
	logic [1:0] owner_d;
	logic [3:0] float_q;
	logic [3:0] float_d;
	logic [2:0] grant_d;
	logic [2:0] wait_pipe_q;
	ebi_mux_pkg::ctl_s ctl [ebi_mux_pkg::CTL_COUNT];
	ebi_mux_pkg::ctl_s cur;
	ebi_mux_pkg::strobe_s strobe_d;
	logic [25:0] addr_d;
	logic [6:0] cs_d;

	// Gather the three controllers into one indexable set.
	assign ctl[0] = static_memory_ctrl_i;
	assign ctl[1] = dynamic_memory_ctrl_i;
	assign ctl[2] = burst_nor_ctrl_i;

	// Owner selection and release decode.
	wire owner_want = ctl[owner_q].want;
	wire burst_hold = (owner_q == ebi_mux_pkg::OWN_BURST) && burst_in_page_i;
	wire release_now = !owner_want && !burst_hold;
	wire [3:0] owner_float = ctl[owner_q].float_cycles;
	wire any_want = ctl[0].want || ctl[1].want || ctl[2].want;
	wire [1:0] pick = ctl[0].want ? ebi_mux_pkg::OWN_STATIC :
		ctl[1].want ? ebi_mux_pkg::OWN_DYNAMIC : ebi_mux_pkg::OWN_BURST;
	assign cur = ctl[owner_q];
	wire own_active = (state_q == ST_OWN);

	// Arbiter: a release with nonzero float_cycles passes through the float wait before a new grant.
	// Refresh never asks for shared pins, so it cannot hold anyone off.
	always_comb
	begin
		state_d = state_q;
		owner_d = owner_q;
		float_d = float_q;
		case (state_q)
			ST_IDLE:
			begin
				if (any_want)
				begin
					state_d = ST_OWN;
					owner_d = pick;
				end
			end
			ST_OWN:
			begin
				if (release_now)
				begin
					float_d = owner_float;
					state_d = (owner_float == 4'h0) ? ST_IDLE : ST_FLOAT;
				end
			end
			ST_FLOAT:
			begin
				float_d = float_q - 4'h1;
				if (float_q == 4'h1)
				begin
					state_d = ST_IDLE;
				end
			end
			default:
			begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Grant follows the next state so it registers with the arbiter state, one cycle ahead of the pins.
	assign grant_d = (state_d == ST_OWN) ? (3'h1 << owner_d) : 3'h0;

	// Card decode; the 16-bit I/O indicator has no port because it plays no part.
	wire card_on = card_slot_assign_i;
	wire card_region = static_xfer_addr_i[31:28] == ebi_mux_pkg::CARD_REGION;
	wire static_own = own_active && (owner_q == ebi_mux_pkg::OWN_STATIC);
	wire card_xfer = card_on && card_region && static_own;
	wire io_mode = static_xfer_addr_i[ebi_mux_pkg::IO_MODE_BIT];
	wire card_io = card_xfer && io_mode;
	wire card_mem = card_xfer && !io_mode;

	// Card byte enables copy chip select four, gated by the active byte lanes.
	// In 8-bit width only the low enable moves, so address bit zero picks the byte.
	wire cs4_b = cur.cs_b[ebi_mux_pkg::CS_CARD];
	wire be_low_b = cs4_b || (cs4_wide_i && !cur.lanes[0]);
	wire be_high_b = cs4_b || !cs4_wide_i || !cur.lanes[1];

	// Chip select pins, with five and six taken over while the slot is assigned.
	always_comb
	begin
		cs_d = own_active ? cur.cs_b : ebi_mux_pkg::CS_IDLE;
		if (card_on && static_own)
		begin
			cs_d[ebi_mux_pkg::CS_BE_LOW] = be_low_b;
			cs_d[ebi_mux_pkg::CS_BE_HIGH] = be_high_b;
		end
		else if (card_on)
		begin
			cs_d[ebi_mux_pkg::CS_BE_LOW] = 1'b1;
			cs_d[ebi_mux_pkg::CS_BE_HIGH] = 1'b1;
		end
	end

	// Shared strobe steering by card mode.
	always_comb
	begin
		strobe_d = '1;
		if (card_io)
		begin
			strobe_d.wr1_b = cur.rd_b;
			strobe_d.wr3_b = cur.wr0_b;
		end
		else if (card_mem)
		begin
			strobe_d.oe_b = cur.rd_b;
			strobe_d.we0_b = cur.wr0_b;
		end
		else if (own_active)
		begin
			strobe_d.oe_b = cur.rd_b;
			strobe_d.we0_b = cur.wr0_b;
			strobe_d.wr1_b = cur.wr1_b;
			strobe_d.wr3_b = cur.wr3_b;
		end
	end

	// Address holds its last value when idle; bit 25 becomes read-not-write for cards.
	always_comb
	begin
		addr_d = own_active ? cur.addr : addr_o;
		if (card_xfer)
		begin
			addr_d[25] = cur.read_not_write;
		end
	end

	// Arbiter state.
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			state_q <= ST_IDLE;
			owner_q <= ebi_mux_pkg::OWN_STATIC;
			float_q <= ebi_mux_pkg::FLOAT_RESET;
			grant_o <= ebi_mux_pkg::GRANT_RESET;
		end
		else if (ce_i)
		begin
			state_q <= state_d;
			owner_q <= owner_d;
			float_q <= float_d;
			grant_o <= grant_d;
		end
	end

	// Registered pins; data drive is dropped outside ownership to avoid contention.
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			addr_o <= ebi_mux_pkg::ADDR_RESET;
			data_o <= ebi_mux_pkg::DATA_RESET;
			data_oe_o <= 1'b0;
			cs_b_o <= ebi_mux_pkg::CS_IDLE;
			strobe_o <= '1;
		end
		else if (ce_i)
		begin
			addr_o <= addr_d;
			data_o <= cur.wdata;
			data_oe_o <= own_active && cur.drive;
			cs_b_o <= cs_d;
			strobe_o <= strobe_d;
		end
	end

	// Dedicated refresh pins pass through one register stage, whoever owns the shared pins.
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			sdram_cmd_o <= ebi_mux_pkg::SDRAM_CMD_IDLE;
		end
		else if (ce_i)
		begin
			sdram_cmd_o <= sdram_cmd_i;
		end
	end

	// Pull-ups cover only lines 0 to 15; the upper half belongs to general I/O.
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			pullup_en_o <= ebi_mux_pkg::PULLUP_RESET;
		end
		else if (ce_i)
		begin
			pullup_en_o <= {16{!data_bus_pullup_disable_i}};
		end
	end

	// Wait pin synchroniser; the output moves only when stages two and three agree.
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			wait_pipe_q <= ebi_mux_pkg::WAIT_SYNC_RESET;
			wait_sync_o <= 1'b0;
		end
		else if (ce_i)
		begin
			wait_pipe_q <= {wait_pipe_q[1:0], external_wait_input_i};
			if (wait_pipe_q[1] == wait_pipe_q[2])
			begin
				wait_sync_o <= wait_pipe_q[2];
			end
		end
	end

	chk_idle_strobes: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		ce_i && state_q == ST_IDLE |=> strobe_o == '1 && cs_b_o[3:0] == 4'hf)
		else $error("strobes active while idle");
	chk_idle_addr: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		ce_i && state_q != ST_OWN |=> $stable(addr_o))
		else $error("address moved while idle");
	chk_float_wait: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		ce_i && state_q == ST_OWN && release_now && owner_float == 4'h2
		##1 ce_i |-> grant_o == 3'h0 ##1 grant_o == 3'h0)
		else $error("regrant inside float time");
	chk_one_grant: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		$onehot0(grant_o))
		else $error("more than one owner");
	chk_burst_hold: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		ce_i && own_active && owner_q == ebi_mux_pkg::OWN_BURST && burst_in_page_i
		|=> state_q == ST_OWN && owner_q == ebi_mux_pkg::OWN_BURST)
		else $error("burst flash lost pins mid page");
	chk_refresh_pass: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		ce_i |=> sdram_cmd_o == $past(sdram_cmd_i))
		else $error("refresh pins delayed");
	chk_pullup_ctl: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		ce_i && data_bus_pullup_disable_i ##1 ce_i && data_bus_pullup_disable_i
		|=> pullup_en_o == 16'h0000)
		else $error("pull-ups not disabled");
	chk_io_mode: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		ce_i && card_io |=> strobe_o.oe_b && strobe_o.we0_b
		&& strobe_o.wr1_b == $past(cur.rd_b))
		else $error("io mode strobes wrong");
	chk_mem_mode: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		ce_i && card_mem |=> strobe_o.wr1_b && strobe_o.wr3_b
		&& strobe_o.we0_b == $past(cur.wr0_b))
		else $error("memory mode strobes wrong");
	chk_card_select: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		ce_i && card_on && static_own && cs4_b |=> cs_b_o[6:4] == 3'h7)
		else $error("byte enable without chip select four");

	// Card and ordinary strobe, direction and chip select pins that the checks above leave open.
	chk_io_write: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		ce_i && card_io |=> strobe_o.wr3_b == $past(cur.wr0_b))
		else $error("io write strobe wrong");
	chk_mem_read: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		ce_i && card_mem |=> strobe_o.oe_b == $past(cur.rd_b))
		else $error("memory read strobe wrong");
	chk_rnw_pin: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		ce_i && card_xfer |=> addr_o[25] == $past(cur.read_not_write))
		else $error("card direction pin wrong");
	chk_plain_strobes: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		ce_i && own_active && !card_xfer |=> strobe_o.wr1_b == $past(cur.wr1_b)
		&& strobe_o.wr3_b == $past(cur.wr3_b) && strobe_o.oe_b == $past(cur.rd_b))
		else $error("ordinary strobes wrong outside card");
	chk_plain_selects: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		ce_i && !card_on && own_active |=> cs_b_o == $past(cur.cs_b))
		else $error("chip selects taken over while slot free");

	// Dropping the data drive between owners keeps two drivers off the bus.
	chk_drive_off: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		ce_i && !own_active |=> !data_oe_o)
		else $error("data bus driven with no owner");
endmodule

// ==== tb/card_side_model.sv ====
// Far-side card model that stretches each selected card access with its wait line.
`timescale 1ns/1ns
module card_side_model
#(
	parameter int WAIT_LEN = 3
)
(
	input wire logic clock_i,
	input wire logic [6:0] cs_b_i,
	input ebi_mux_pkg::strobe_s strobe_i,
	output logic wait_o
);
	int cnt = 0;

	// A selected card with any strobe low asks for wait; a larger WAIT_LEN models a slow card.
	always @(posedge clock_i)
	begin
		if (!cs_b_i[4] && strobe_i !== 4'hf && cnt == 0)
			cnt <= WAIT_LEN;
		else if (cnt > 0)
			cnt <= cnt - 1;
	end
	assign wait_o = (cnt > 0);
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the pin multiplexer and its card decode.
`timescale 1ns/1ns
module tb_top;
	logic clock_i = 1'b0;
	logic rst_b_i = 1'b0;
	ebi_mux_pkg::ctl_s st = '0;
	ebi_mux_pkg::ctl_s dy = '0;
	ebi_mux_pkg::ctl_s bu = '0;
	logic [31:0] xa = '0;
	logic wide = 1'b0;
	logic inpg = 1'b0;
	logic asg = 1'b0;
	logic pud = 1'b0;
	logic [3:0] sdc = 4'hf;
	logic wait_b;
	logic [2:0] grant_o;
	logic [25:0] addr_o;
	logic [31:0] data_o;
	logic data_oe_o;
	logic [6:0] cs_b_o;
	ebi_mux_pkg::strobe_s strobe_o;
	logic [3:0] sdram_cmd_o;
	logic [15:0] pullup_en_o;
	logic wait_sync_o;
	logic [31:0] rs = 32'h78246724;
	logic [95:0] w;
	logic [3:0] fl [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h7};
	logic ce = 1'b1;
	logic [25:0] ha;
	int wq[$] = '{0, 0, 0};
	logic wexp = 1'b0;
	logic card;
	logic [6:0] ecs;
	logic [3:0] es;
	int n_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	int n = 0;
	int waits = 0;

	// Clock at 50 ns period.
	always #25 clock_i = ~clock_i;

	ext_bus_pin_mux_card_logic i_ext_bus_pin_mux_card_logic
	(
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.ce_i(ce),
		.static_memory_ctrl_i(st),
		.dynamic_memory_ctrl_i(dy),
		.burst_nor_ctrl_i(bu),
		.static_xfer_addr_i(xa),
		.cs4_wide_i(wide),
		.burst_in_page_i(inpg),
		.sdram_cmd_i(sdc),
		.card_slot_assign_i(asg),
		.data_bus_pullup_disable_i(pud),
		.external_wait_input_i(wait_b),
		.grant_o(grant_o),
		.addr_o(addr_o),
		.data_o(data_o),
		.data_oe_o(data_oe_o),
		.cs_b_o(cs_b_o),
		.strobe_o(strobe_o),
		.sdram_cmd_o(sdram_cmd_o),
		.pullup_en_o(pullup_en_o),
		.wait_sync_o(wait_sync_o)
	);

	card_side_model i_card_side_model
	(
		.clock_i(clock_i),
		.cs_b_i(cs_b_o),
		.strobe_i(strobe_o),
		.wait_o(wait_b)
	);

	function logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task final_report();
		$display("compares %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Every falling edge also compares the wait output with the reference stages.
	task step();
		@(negedge clock_i);
		chk(32'(wait_sync_o), 32'(wexp));
	endtask

	// Bounded wait, because a lost grant would otherwise hang the run.
	task wait_grant(input logic [2:0] g);
		n = 0;
		do
		begin
			step();
			n++;
		end
		while (grant_o !== g && n < 40);
		chk(32'(grant_o), 32'(g));
	endtask

	// Hang guard and a tally of synchronised wait cycles.
	always @(posedge clock_i)
	begin
		cyc <= cyc + 1;
		waits <= waits + 32'(wait_sync_o === 1'b1);
		if (cyc == 3000)
		begin
			n_errors++;
			final_report();
		end
	end

	// Reference synchroniser: three stages, and the output moves once the last two agree.
	always @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			wq = '{0, 0, 0};
			wexp <= 1'b0;
		end
		else if (ce)
		begin
			if (wq[1] == wq[2])
				wexp <= (wq[2] != 0);
			wq.push_front(int'(wait_b));
			void'(wq.pop_back());
		end
	end

	initial
	begin
		repeat (2) step();
		chk(32'(grant_o), 32'h0);
		chk(32'(cs_b_o), 32'h7f);
		chk(32'(strobe_o), 32'hf);
		chk(32'(pullup_en_o), 32'hffff);
		rst_b_i = 1'b1;
		$display("test reset done");
		st.want = 1'b1;
		wait_grant(3'h1);
		// Random static traffic; other wants are raised too and must be ignored.
		for (int i = 0; i < 300; i++)
		begin
			w = {rnd(), rnd(), rnd()};
			// The static strobes already carry the chip select four setup and hold.
			st = w[77:0];
			st.want = 1'b1;
			st.float_cycles = 4'h0;
			dy.want = w[80];
			bu.want = w[81];
			// Bit 22 plays the card's attribute select, so the decode must ignore it.
			xa = rnd();
			if (xa[0])
				xa[31:28] = 4'h5;
			// The two regions behind the byte enables are never touched.
			if (xa[31:29] == 3'h3)
				xa[31] = 1'b1;
			{asg, wide, pud, sdc} = w[88:82];
			step();
			card = asg && xa[31:28] == 4'h5;
			ecs = st.cs_b;
			if (asg)
				ecs[6:5] = {ecs[4] | ~wide | ~st.lanes[1], ecs[4] | (wide & ~st.lanes[0])};
			es = {st.rd_b, st.wr0_b, st.wr1_b, st.wr3_b};
			if (card)
				es = xa[23] ? {2'h3, st.rd_b, st.wr0_b} : {st.rd_b, st.wr0_b, 2'h3};
			chk(32'(grant_o), 32'h1);
			chk(32'(addr_o), 32'({card ? st.read_not_write : st.addr[25], st.addr[24:0]}));
			chk(data_o, st.wdata);
			chk(32'(data_oe_o), 32'(st.drive));
			chk(32'(cs_b_o), 32'(ecs));
			chk(32'(strobe_o), 32'(es));
			chk(32'(pullup_en_o), pud ? 32'h0 : 32'hffff);
			chk(32'(sdram_cmd_o), 32'(sdc));
		end
		$display("test card decode done");
		foreach (fl[k])
		begin
			st = '1;
			st.want = 1'b0;
			st.float_cycles = fl[k];
			dy = w[77:0];
			dy.want = 1'b1;
			bu.want = 1'b0;
			n = 0;
			step();
			while (grant_o !== 3'h2 && n < 40)
			begin
				chk(32'(strobe_o), 32'hf);
				n++;
				step();
			end
			chk(32'(n), 32'(fl[k]) + 32'h1);
			// Pins follow one cycle behind the grant.
			step();
			chk(32'(addr_o), 32'(dy.addr));
			dy.want = 1'b0;
			dy.float_cycles = 4'h0;
			st.want = 1'b1;
			st.float_cycles = 4'h0;
			wait_grant(3'h1);
		end
		$display("test float handover done");
		st.want = 1'b0;
		bu.want = 1'b1;
		inpg = 1'b1;
		wait_grant(3'h4);
		bu.want = 1'b0;
		st.want = 1'b1;
		repeat (4)
		begin
			step();
			chk(32'(grant_o), 32'h4);
		end
		inpg = 1'b0;
		wait_grant(3'h1);
		chk(32'(waits > 0), 32'h1);
		$display("test burst hold done");
		// Clock enable low must freeze every pin, whatever the inputs do.
		ha = addr_o;
		es = strobe_o;
		ce = 1'b0;
		st.want = 1'b0;
		st.addr = ~st.addr;
		repeat (3)
		begin
			step();
			chk(32'(grant_o), 32'h1);
			chk(32'(addr_o), 32'(ha));
			chk(32'(strobe_o), 32'(es));
		end
		ce = 1'b1;
		st.want = 1'b1;
		step();
		chk(32'(grant_o), 32'h1);
		$display("test clock enable done");
		final_report();
	end
endmodule
